// >>> verilog/mmutw_top.v
`include "mmutw_regs.vh"
`default_nettype none
module mmutw_top (
	input  wire        sys_clk_i,
	input  wire        srst_i,
	input  wire        cp_wr_i,
	input  wire        cp_rd_i,
	input  wire [3:0]  cp_reg_i,
	input  wire [2:0]  cp_op2_i,
	input  wire [3:0]  cp_crm_i,
	input  wire [31:0] cp_wdata_i,
	output reg  [31:0] cp_rdata_o,
	output reg         cp_rvalid_o,
	input  wire        d_req_i,
	input  wire [31:0] d_addr_i,
	input  wire        d_wr_i,
	input  wire [1:0]  d_size_i,
	input  wire        d_priv_i,
	output wire        d_busy_o,
	output wire        d_done_o,
	output wire        d_abort_o,
	output wire [31:0] d_phys_o,
	output wire        d_cache_o,
	output wire        d_buf_o,
	input  wire        i_req_i,
	input  wire [31:0] i_addr_i,
	input  wire        i_priv_i,
	output wire        i_busy_o,
	output wire        i_done_o,
	output wire        i_abort_o,
	output wire [31:0] i_phys_o,
	output wire        i_cache_o,
	output wire        i_buf_o,
	output reg         mem_req_o,
	output reg  [31:0] mem_addr_o,
	input  wire        mem_ack_i,
	input  wire [31:0] mem_rdata_i
);
	localparam P_IDLE = 2'h0;
	localparam P_LOOK = 2'h1;
	localparam P_CHK  = 2'h2;
	localparam P_WALK = 2'h3;
	localparam W_IDLE = 2'h0;
	localparam W_L1   = 2'h1;
	localparam W_L2   = 2'h2;
	localparam W_DONE = 2'h3;

	reg  [31:0] ctl;
	reg  [17:0] tbase;
	reg  [31:0] dac;
	reg  [7:0]  fsr;
	reg  [31:0] far;
	reg  [6:0]  pid;
	reg  [1:0]  wst;
	reg         own;
	reg  [31:0] wva;
	reg         w_done;
	reg         w_flt;
	reg  [3:0]  w_code;
	reg  [3:0]  w_dom;
	reg  [31:0] f_pa;
	reg  [1:0]  f_sz;
	reg  [7:0]  f_ap;
	reg  [1:0]  f_cb;
	wire        mmu_on;
	wire        ack;
	wire [1:0]  p_req;
	wire [63:0] p_addr;
	wire [1:0]  p_wr;
	wire [3:0]  p_size;
	wire [1:0]  p_priv;
	wire [1:0]  wreq;
	wire [63:0] mva_all;
	wire [63:0] lk_rd;
	wire [1:0]  busy_v;
	wire [1:0]  done_v;
	wire [1:0]  abt_v;
	wire [63:0] phys_v;
	wire [1:0]  cch_v;
	wire [1:0]  bfr_v;
	wire        ab_ev;
	wire [7:0]  ab_fs;
	wire [31:0] ab_va;
	wire [31:0] gva;
	wire [1:0]  inv_all;
	wire [1:0]  inv_one;

	// permission by access-permission bits and scheme bits
	function apok;
		input [1:0] ap;
		input       pv;
		input       w;
		input       s;
		input       r;
		begin
			case (ap)
			2'h0:    apok = !w && ((s && !r && pv) || (!s && r));
			2'h1:    apok = pv;
			2'h2:    apok = pv || !w;
			default: apok = 1'b1;
			endcase
		end
	endfunction

	// index 0 is the data port, index 1 the instruction port
	assign p_req  = {i_req_i, d_req_i};
	assign p_addr = {i_addr_i, d_addr_i};
	assign p_wr   = {1'b0, d_wr_i};
	assign p_size = {`MMUTW_SIZE_WORD, d_size_i};
	assign p_priv = {i_priv_i, d_priv_i};
	assign mmu_on = ctl[`MMUTW_CTL_M];
	assign ack    = mem_req_o & mem_ack_i;
	assign gva    = wreq[0] ? mva_all[31:0] : mva_all[63:32];

	assign d_busy_o  = busy_v[0];
	assign d_done_o  = done_v[0];
	assign d_abort_o = abt_v[0];
	assign d_phys_o  = phys_v[31:0];
	assign d_cache_o = cch_v[0];
	assign d_buf_o   = bfr_v[0];
	assign i_busy_o  = busy_v[1];
	assign i_done_o  = done_v[1];
	assign i_abort_o = abt_v[1];
	assign i_phys_o  = phys_v[63:32];
	assign i_cache_o = cch_v[1];
	assign i_buf_o   = bfr_v[1];

	// ----------------------------------------
	// coprocessor registers
	// ----------------------------------------
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_op
			assign inv_all[p] = cp_wr_i && (cp_reg_i == `MMUTW_REG_TLBOP) &&
			                    (cp_op2_i == `MMUTW_OP2_INVALL) &&
			                    (cp_crm_i == `MMUTW_CRM_BOTH ||
			                     cp_crm_i == ((p == 0) ? `MMUTW_CRM_DTLB : `MMUTW_CRM_ITLB));
			assign inv_one[p] = cp_wr_i && (cp_reg_i == `MMUTW_REG_TLBOP) &&
			                    (cp_op2_i == `MMUTW_OP2_INVONE) &&
			                    (cp_crm_i == `MMUTW_CRM_BOTH ||
			                     cp_crm_i == ((p == 0) ? `MMUTW_CRM_DTLB : `MMUTW_CRM_ITLB));
		end
	endgenerate

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctl   <= 32'h00000000;
			tbase <= 18'h00000;
			dac   <= 32'h00000000;
			fsr   <= 8'h00;
			far   <= 32'h00000000;
			pid   <= 7'h00;
		end else begin
			if (cp_wr_i) begin
				case (cp_reg_i)
				`MMUTW_REG_CTRL:   ctl   <= cp_wdata_i & `MMUTW_CTL_MASK;
				`MMUTW_REG_TBASE:  tbase <= cp_wdata_i[31:14];
				`MMUTW_REG_DOMAIN: dac   <= cp_wdata_i;
				`MMUTW_REG_FSTAT:  fsr   <= cp_wdata_i[7:0];
				`MMUTW_REG_FADDR:  far   <= cp_wdata_i;
				`MMUTW_REG_PID:    pid   <= cp_wdata_i[31:25];
				default:           ctl   <= ctl;
				endcase
			end
			if (ab_ev) begin
				fsr <= ab_fs;
				far <= ab_va;
			end
		end
	end

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			cp_rvalid_o <= 1'b0;
			cp_rdata_o  <= 32'h00000000;
		end else begin
			cp_rvalid_o <= cp_rd_i;
			cp_rdata_o  <= 32'h00000000;
			if (cp_rd_i) begin
				case (cp_reg_i)
				`MMUTW_REG_CTRL:   cp_rdata_o <= ctl;
				`MMUTW_REG_TBASE:  cp_rdata_o <= {tbase, 14'h0000};
				`MMUTW_REG_DOMAIN: cp_rdata_o <= dac;
				`MMUTW_REG_FSTAT:  cp_rdata_o <= {24'h000000, fsr};
				`MMUTW_REG_FADDR:  cp_rdata_o <= far;
				`MMUTW_REG_LOCK:   cp_rdata_o <= (cp_op2_i == `MMUTW_OP2_INSTR) ? lk_rd[63:32] : lk_rd[31:0];
				`MMUTW_REG_PID:    cp_rdata_o <= {pid, 25'h0000000};
				default:           cp_rdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// table walker
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			wst        <= W_IDLE;
			own        <= 1'b0;
			wva        <= 32'h00000000;
			mem_req_o  <= 1'b0;
			mem_addr_o <= 32'h00000000;
			w_done     <= 1'b0;
			w_flt      <= 1'b0;
			w_code     <= 4'h0;
			w_dom      <= 4'h0;
			f_pa       <= 32'h00000000;
			f_sz       <= 2'h0;
			f_ap       <= 8'h00;
			f_cb       <= 2'h0;
		end else begin
			w_done <= 1'b0;
			case (wst)
			W_IDLE: begin
				if (|wreq) begin
					own        <= ~wreq[0];
					wva        <= gva;
					mem_req_o  <= 1'b1;
					mem_addr_o <= {tbase, gva[31:20], 2'h0};
					wst        <= W_L1;
				end
			end
			W_L1: begin
				if (ack) begin
					mem_req_o <= 1'b0;
					w_done    <= 1'b1;
					w_flt     <= 1'b0;
					w_dom     <= mem_rdata_i[8:5];
					f_cb      <= mem_rdata_i[3:2];
					wst       <= W_DONE;
					case (mem_rdata_i[1:0])
					`MMUTW_L1_FAULT: begin
						w_flt  <= 1'b1;
						w_code <= `MMUTW_FS_TRS;
					end
					`MMUTW_L1_SEC: begin
						f_pa <= {mem_rdata_i[31:20], 20'h00000};
						f_sz <= `MMUTW_SZ_SEC;
						f_ap <= {4{mem_rdata_i[11:10]}};
					end
					`MMUTW_L1_COARSE: begin
						mem_req_o  <= 1'b1;
						w_done     <= 1'b0;
						mem_addr_o <= {mem_rdata_i[31:10], wva[19:12], 2'h0};
						wst        <= W_L2;
					end
					default: begin
						mem_req_o  <= 1'b1;
						w_done     <= 1'b0;
						mem_addr_o <= {mem_rdata_i[31:12], wva[19:10], 2'h0};
						wst        <= W_L2;
					end
					endcase
				end
			end
			W_L2: begin
				if (ack) begin
					mem_req_o <= 1'b0;
					w_done    <= 1'b1;
					w_flt     <= 1'b0;
					f_cb      <= mem_rdata_i[3:2];
					f_ap      <= mem_rdata_i[11:4];
					wst       <= W_DONE;
					case (mem_rdata_i[1:0])
					`MMUTW_L2_FAULT: begin
						w_flt  <= 1'b1;
						w_code <= `MMUTW_FS_TRP;
					end
					`MMUTW_L2_LARGE: begin
						f_pa <= {mem_rdata_i[31:16], 16'h0000};
						f_sz <= `MMUTW_SZ_LARGE;
					end
					`MMUTW_L2_SMALL: begin
						f_pa <= {mem_rdata_i[31:12], 12'h000};
						f_sz <= `MMUTW_SZ_SMALL;
					end
					default: begin
						f_pa <= {mem_rdata_i[31:10], 10'h000};
						f_sz <= `MMUTW_SZ_TINY;
						f_ap <= {4{mem_rdata_i[5:4]}};
					end
					endcase
				end
			end
			W_DONE: wst <= W_IDLE;
			default: wst <= W_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// per-port lookup and check
	// ----------------------------------------
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_port
			reg  [1:0]  st;
			reg  [31:0] mva;
			reg         wr;
			reg         priv;
			reg  [1:0]  sz;
			reg         busy;
			reg         done;
			reg         abt;
			reg  [31:0] phys;
			reg         cch;
			reg         bfr;
			reg  [5:0]  base;
			reg  [5:0]  vict;
			reg         pre;
			reg         ev;
			reg  [7:0]  ev_fs;
			wire        t_hit;
			wire [31:0] t_pa;
			wire [1:0]  t_ap;
			wire [3:0]  t_dom;
			wire [1:0]  t_cb;
			wire        t_sec;
			wire [1:0]  dmode;
			wire        misal;
			wire        fill;
			wire [31:0] raw;

			assign raw   = p_addr[p*32 +: 32];
			assign dmode = dac[{t_dom, 1'b0} +: 2];
			assign misal = (p == 0) && ctl[`MMUTW_CTL_A] &&
			               ((sz == `MMUTW_SIZE_HALF && mva[0]) ||
			                (sz == `MMUTW_SIZE_WORD && mva[1:0] != 2'h0));
			assign fill  = w_done && !w_flt && (own == p);
			assign wreq[p]            = (st == P_WALK) && !w_done;
			assign mva_all[p*32 +: 32] = mva;
			assign lk_rd[p*32 +: 32]   = {base, vict, 19'h00000, pre};
			assign busy_v[p]           = busy;
			assign done_v[p]           = done;
			assign abt_v[p]            = abt;
			assign phys_v[p*32 +: 32]  = phys;
			assign cch_v[p]            = cch;
			assign bfr_v[p]            = bfr;

			mmutw_tlb u_tlb (
				.sys_clk_i (sys_clk_i),
				.srst_i    (srst_i),
				.lk_va_i   (mva),
				.hit_o     (t_hit),
				.pa_o      (t_pa),
				.ap_o      (t_ap),
				.dom_o     (t_dom),
				.cb_o      (t_cb),
				.sec_o     (t_sec),
				.we_i      (fill),
				.widx_i    (vict),
				.wva_i     (wva),
				.wpa_i     (f_pa),
				.wsz_i     (f_sz),
				.wap_i     (f_ap),
				.wdom_i    (w_dom),
				.wcb_i     (f_cb),
				.wpre_i    (pre),
				.inv_all_i (inv_all[p]),
				.inv_one_i (inv_one[p]),
				.inv_va_i  (cp_wdata_i)
			);

			always @(posedge sys_clk_i) begin
				if (srst_i) begin
					st    <= P_IDLE;
					mva   <= 32'h00000000;
					wr    <= 1'b0;
					priv  <= 1'b0;
					sz    <= 2'h0;
					busy  <= 1'b0;
					done  <= 1'b0;
					abt   <= 1'b0;
					phys  <= 32'h00000000;
					cch   <= 1'b0;
					bfr   <= 1'b0;
					base  <= 6'h00;
					vict  <= 6'h00;
					pre   <= 1'b0;
					ev    <= 1'b0;
					ev_fs <= 8'h00;
				end else begin
					done <= 1'b0;
					abt  <= 1'b0;
					ev   <= 1'b0;
					case (st)
					P_IDLE: begin
						if (p_req[p]) begin
							mva  <= (raw[31:25] == 7'h00) ? {pid, raw[24:0]} : raw;
							wr   <= p_wr[p];
							priv <= p_priv[p];
							sz   <= p_size[p*2 +: 2];
							busy <= 1'b1;
							st   <= P_LOOK;
						end
					end
					P_LOOK: st <= P_CHK;
					P_CHK: begin
						st   <= P_IDLE;
						busy <= 1'b0;
						if (misal) begin
							abt   <= 1'b1;
							ev    <= 1'b1;
							ev_fs <= {4'h0, `MMUTW_FS_ALIGN};
						end else if (!mmu_on) begin
							done <= 1'b1;
							phys <= mva;
							cch  <= 1'b0;
							bfr  <= 1'b0;
						end else if (!t_hit) begin
							st   <= P_WALK;
							busy <= 1'b1;
						end else if (dmode != `MMUTW_DOM_CLIENT && dmode != `MMUTW_DOM_MGR) begin
							abt   <= 1'b1;
							ev    <= (p == 0);
							ev_fs <= {t_dom, t_sec ? `MMUTW_FS_DOMS : `MMUTW_FS_DOMP};
						end else if (dmode == `MMUTW_DOM_CLIENT &&
						             !apok(t_ap, priv, wr, ctl[`MMUTW_CTL_S], ctl[`MMUTW_CTL_R])) begin
							abt   <= 1'b1;
							ev    <= (p == 0);
							ev_fs <= {t_dom, t_sec ? `MMUTW_FS_PRMS : `MMUTW_FS_PRMP};
						end else begin
							done <= 1'b1;
							phys <= t_pa;
							cch  <= t_cb[1];
							bfr  <= t_cb[0];
						end
					end
					P_WALK: begin
						if (w_done && own == p) begin
							if (w_flt) begin
								st    <= P_IDLE;
								busy  <= 1'b0;
								abt   <= 1'b1;
								ev    <= (p == 0);
								ev_fs <= {w_dom, w_code};
							end else begin
								st <= P_LOOK;
							end
						end
					end
					default: st <= P_IDLE;
					endcase
					if (fill)
						vict <= (vict == `MMUTW_TLB_LAST) ? base : vict + 6'h01;
					if (cp_wr_i && cp_reg_i == `MMUTW_REG_LOCK && cp_op2_i == p) begin
						base <= cp_wdata_i[31:26];
						vict <= cp_wdata_i[25:20];
						pre  <= cp_wdata_i[0];
					end
				end
			end
			if (p == 0) begin : g_ev
				assign ab_ev = ev;
				assign ab_fs = ev_fs;
				assign ab_va = mva;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> verilog/mmutw_regs.vh
`ifndef MMUTW_REGS_VH
`define MMUTW_REGS_VH
// ----------------------------------------
// register numbers
// ----------------------------------------
`define MMUTW_REG_CTRL   4'h1
`define MMUTW_REG_TBASE  4'h2
`define MMUTW_REG_DOMAIN 4'h3
`define MMUTW_REG_FSTAT  4'h5
`define MMUTW_REG_FADDR  4'h6
`define MMUTW_REG_TLBOP  4'h8
`define MMUTW_REG_LOCK   4'hA
`define MMUTW_REG_PID    4'hD
`define MMUTW_OP2_DATA   3'h0
`define MMUTW_OP2_INSTR  3'h1
`define MMUTW_OP2_INVALL 3'h0
`define MMUTW_OP2_INVONE 3'h1
`define MMUTW_CRM_ITLB   4'h5
`define MMUTW_CRM_DTLB   4'h6
`define MMUTW_CRM_BOTH   4'h7
// ----------------------------------------
// fields
// ----------------------------------------
`define MMUTW_CTL_M      0
`define MMUTW_CTL_A      1
`define MMUTW_CTL_S      8
`define MMUTW_CTL_R      9
`define MMUTW_CTL_MASK   32'h00000303
`define MMUTW_LK_BASE    26
`define MMUTW_LK_VICT    20
`define MMUTW_TLB_LAST   6'h3F
`define MMUTW_SZ_SEC     2'h0
`define MMUTW_SZ_LARGE   2'h1
`define MMUTW_SZ_SMALL   2'h2
`define MMUTW_SZ_TINY    2'h3
`define MMUTW_L1_FAULT   2'h0
`define MMUTW_L1_COARSE  2'h1
`define MMUTW_L1_SEC     2'h2
`define MMUTW_L2_FAULT   2'h0
`define MMUTW_L2_LARGE   2'h1
`define MMUTW_L2_SMALL   2'h2
`define MMUTW_DOM_CLIENT 2'h1
`define MMUTW_DOM_MGR    2'h3
`define MMUTW_SIZE_HALF  2'h1
`define MMUTW_SIZE_WORD  2'h2
`define MMUTW_FS_ALIGN   4'h1
`define MMUTW_FS_TRS     4'h5
`define MMUTW_FS_TRP     4'h7
`define MMUTW_FS_DOMS    4'h9
`define MMUTW_FS_DOMP    4'hB
`define MMUTW_FS_PRMS    4'hD
`define MMUTW_FS_PRMP    4'hF
`endif

// >>> verilog/mmutw_tlb.v
`include "mmutw_regs.vh"
`default_nettype none
module mmutw_tlb (
	input  wire        sys_clk_i,
	input  wire        srst_i,
	input  wire [31:0] lk_va_i,
	output reg         hit_o,
	output reg  [31:0] pa_o,
	output reg  [1:0]  ap_o,
	output reg  [3:0]  dom_o,
	output reg  [1:0]  cb_o,
	output reg         sec_o,
	input  wire        we_i,
	input  wire [5:0]  widx_i,
	input  wire [31:0] wva_i,
	input  wire [31:0] wpa_i,
	input  wire [1:0]  wsz_i,
	input  wire [7:0]  wap_i,
	input  wire [3:0]  wdom_i,
	input  wire [1:0]  wcb_i,
	input  wire        wpre_i,
	input  wire        inv_all_i,
	input  wire        inv_one_i,
	input  wire [31:0] inv_va_i
);
	reg [63:0] vld;
	reg [63:0] pre;
	reg [21:0] tag [0:63];
	reg [21:0] pab [0:63];
	reg [1:0]  szm [0:63];
	reg [7:0]  apm [0:63];
	reg [3:0]  dm  [0:63];
	reg [1:0]  cbm [0:63];
	reg [5:0]  sel;
	wire [63:0] m_lk;
	wire [63:0] m_inv;
	wire [1:0]  sb;
	// mapping granule masks
	function [31:0] msk;
		input [1:0] s;
		begin
			case (s)
			`MMUTW_SZ_SEC:   msk = 32'hFFF00000;
			`MMUTW_SZ_LARGE: msk = 32'hFFFF0000;
			`MMUTW_SZ_SMALL: msk = 32'hFFFFF000;
			default:         msk = 32'hFFFFFC00;
			endcase
		end
	endfunction
	function hitf;
		input [21:0] t;
		input [1:0]  s;
		input [31:0] va;
		begin
			hitf = ((({t, 10'h000} ^ va) & msk(s)) == 32'h00000000);
		end
	endfunction
	// ----------------------------------------
	// match
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 64; g = g + 1) begin : g_cmp
			assign m_lk[g]  = vld[g] & hitf(tag[g], szm[g], lk_va_i);
			assign m_inv[g] = vld[g] & hitf(tag[g], szm[g], inv_va_i);
		end
	endgenerate
	always @* begin : pick
		integer k;
		sel = 6'h00;
		for (k = 63; k >= 0; k = k - 1) begin
			if (m_lk[k])
				sel = k[5:0];
		end
	end
	assign sb = (szm[sel] == `MMUTW_SZ_LARGE) ? lk_va_i[15:14] :
	            (szm[sel] == `MMUTW_SZ_SMALL) ? lk_va_i[11:10] : 2'h0;
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			hit_o <= 1'b0;
			pa_o  <= 32'h00000000;
			ap_o  <= 2'h0;
			dom_o <= 4'h0;
			cb_o  <= 2'h0;
			sec_o <= 1'b0;
		end else begin
			hit_o <= |m_lk;
			pa_o  <= ({pab[sel], 10'h000} & msk(szm[sel])) | (lk_va_i & ~msk(szm[sel]));
			ap_o  <= apm[sel][{sb, 1'b0} +: 2];
			dom_o <= dm[sel];
			cb_o  <= cbm[sel];
			sec_o <= (szm[sel] == `MMUTW_SZ_SEC);
		end
	end
	// ----------------------------------------
	// storage
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (we_i) begin
			tag[widx_i] <= wva_i[31:10];
			pab[widx_i] <= wpa_i[31:10];
			szm[widx_i] <= wsz_i;
			apm[widx_i] <= wap_i;
			dm[widx_i]  <= wdom_i;
			cbm[widx_i] <= wcb_i;
		end
	end
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			vld <= 64'h0000000000000000;
			pre <= 64'h0000000000000000;
		end else begin
			vld <= vld & ~({64{inv_all_i}} & ~pre) & ~({64{inv_one_i}} & m_inv);
			if (we_i) begin
				vld[widx_i] <= 1'b1;
				pre[widx_i] <= wpre_i;
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/mmutw_top_asserts.sv
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module mmutw_top_asserts (
	input wire logic        sys_clk_i,
	input wire logic        srst_i,
	input wire logic        cp_wr_i,
	input wire logic        cp_rd_i,
	input wire logic [3:0]  cp_reg_i,
	input wire logic [31:0] cp_wdata_i,
	input wire logic [31:0] cp_rdata_o,
	input wire logic        cp_rvalid_o,
	input wire logic        d_req_i,
	input wire logic [31:0] d_addr_i,
	input wire logic        d_busy_o,
	input wire logic        d_done_o,
	input wire logic        d_abort_o,
	input wire logic [31:0] d_phys_o,
	input wire logic        d_cache_o,
	input wire logic        d_buf_o,
	input wire logic        i_busy_o,
	input wire logic        i_done_o,
	input wire logic        i_abort_o,
	input wire logic        mem_req_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic        mem_ack_i
);
	logic        m_on;
	logic        pid_z;
	logic [31:0] tbase_q;
	logic [31:0] d_va;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// shadow of enable, base, relocation and accepted address
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			m_on <= 1'b0;
			pid_z <= 1'b1;
			tbase_q <= 32'h0;
			d_va <= 32'h0;
		end else begin
			if (cp_wr_i && cp_reg_i == 4'h1)
				m_on <= cp_wdata_i[0];
			if (cp_wr_i && cp_reg_i == 4'hD)
				pid_z <= cp_wdata_i[31:25] == 7'h0;
			if (cp_wr_i && cp_reg_i == 4'h2)
				tbase_q <= cp_wdata_i;
			if (d_req_i && !d_busy_o)
				d_va <= d_addr_i;
		end
	end
	rd_answer_a: assert property (cp_rd_i |=> cp_rvalid_o) else $error("read not answered");
	rvalid_cause_a: assert property (cp_rvalid_o |-> $past(cp_rd_i)) else $error("stray read valid");
	tbase_low_a: assert property (cp_rvalid_o && $past(cp_reg_i) == 4'h2 |-> cp_rdata_o[13:0] == 14'h0)
		else $error("base low bits not zero");
	maint_wo_a: assert property (cp_rvalid_o && $past(cp_reg_i) == 4'h8 |-> cp_rdata_o == 32'h0)
		else $error("maintenance register readable");
	pulse_excl_a: assert property (!(d_done_o && d_abort_o)) else $error("done with abort");
	busy_end_a: assert property ($fell(d_busy_o) |-> d_done_o || d_abort_o) else $error("busy ended silently");
	ibusy_end_a: assert property ($fell(i_busy_o) |-> i_done_o || i_abort_o) else $error("fetch busy ended silently");
	off_latency_a: assert property (d_req_i && !d_busy_o && !m_on |=> d_busy_o ##1 d_busy_o ##1 (d_done_o || d_abort_o))
		else $error("flat access latency wrong");
	flat_map_a: assert property (d_done_o && !m_on && pid_z |-> d_phys_o == d_va && !d_cache_o && !d_buf_o)
		else $error("flat mapping wrong");
	no_walk_off_a: assert property (!m_on |-> !mem_req_o) else $error("walk while disabled");
	walk_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("fetch dropped before ack");
	l1_addr_a: assert property ($rose(mem_req_o) |-> mem_addr_o[31:14] == tbase_q[31:14] && mem_addr_o[1:0] == 2'h0)
		else $error("first fetch address wrong");
endmodule
bind mmutw_top mmutw_top_asserts u_chk (.sys_clk_i, .srst_i, .cp_wr_i, .cp_rd_i, .cp_reg_i, .cp_wdata_i,
	.cp_rdata_o, .cp_rvalid_o, .d_req_i, .d_addr_i, .d_busy_o, .d_done_o, .d_abort_o, .d_phys_o,
	.d_cache_o, .d_buf_o, .i_busy_o, .i_done_o, .i_abort_o, .mem_req_o, .mem_addr_o, .mem_ack_i);
`default_nettype wire

// >>> bench/mmutw_mem_model.sv
`default_nettype none
// ----------------------------------------
// table memory
// ----------------------------------------
module mmutw_mem_model (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic        slow_i,
	input  wire logic        req_i,
	input  wire logic [31:0] addr_i,
	output var logic         ack_o,
	output var logic [31:0]  rdata_o,
	output var int           fetches_o
);
	logic [2:0] wait_cnt;
	function automatic logic [31:0] desc(input logic [31:0] a);
		case (a)
			32'h0000448C: desc = 32'hABC00C1E;
			32'h00004800: desc = 32'h00100011;
			32'h00100158: desc = 32'h77777FF2;
			32'h00004084: desc = 32'h5550041E;
			default:      desc = 32'h000001E0;
		endcase
	endfunction
	// data lines toggle whenever no answer is given outside reset
	always @(posedge sys_clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (srst_i) begin
			wait_cnt <= 3'h0;
			fetches_o <= 0;
			rdata_o <= 32'h5A5A5A5A;
		end else if (req_i && !ack_o) begin
			if (wait_cnt >= (slow_i ? 3'h5 : 3'h0)) begin
				ack_o <= 1'b1;
				rdata_o <= desc(addr_i);
				fetches_o <= fetches_o + 1;
				wait_cnt <= 3'h0;
			end else
				wait_cnt <= wait_cnt + 3'h1;
		end
	end
endmodule
`default_nettype wire

// >>> bench/mmutw_top_tb.sv
`default_nettype none
module mmutw_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i = 1'b0, srst_i = 1'b1, cp_wr_i = 1'b0, cp_rd_i = 1'b0;
	logic        d_req_i = 1'b0, d_wr_i = 1'b0, i_req_i = 1'b0, slow = 1'b0, d_priv_i = 1'b1;
	logic [1:0]  d_size_i = 2'h0;
	logic [2:0]  cp_op2_i = 3'h0;
	logic [3:0]  cp_reg_i = 4'h0, cp_crm_i = 4'h7;
	logic [31:0] cp_wdata_i = 32'h0, d_addr_i = 32'h0, i_addr_i = 32'h0, off;
	wire logic [31:0] cp_rdata_o, d_phys_o, i_phys_o, mem_addr_o, mem_rdata_i;
	wire logic   cp_rvalid_o, d_busy_o, d_done_o, d_abort_o, d_cache_o, d_buf_o;
	wire logic   i_busy_o, i_done_o, i_abort_o, i_cache_o, i_buf_o, mem_req_o, mem_ack_i;
	int          fails = 0, compares = 0, cycles = 0, seed = 92489, fetches;
	logic [34:0] expq[$];
	mmutw_top DUT (.sys_clk_i, .srst_i, .cp_wr_i, .cp_rd_i, .cp_reg_i, .cp_op2_i, .cp_crm_i, .cp_wdata_i,
		.cp_rdata_o, .cp_rvalid_o, .d_req_i, .d_addr_i, .d_wr_i, .d_size_i, .d_priv_i, .d_busy_o,
		.d_done_o, .d_abort_o, .d_phys_o, .d_cache_o, .d_buf_o, .i_req_i, .i_addr_i, .i_priv_i(1'b1),
		.i_busy_o, .i_done_o, .i_abort_o, .i_phys_o, .i_cache_o, .i_buf_o, .mem_req_o, .mem_addr_o,
		.mem_ack_i, .mem_rdata_i);
	mmutw_mem_model u_mem (.sys_clk_i, .srst_i, .slow_i(slow), .req_i(mem_req_o), .addr_i(mem_addr_o),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i), .fetches_o(fetches));
	always #4 sys_clk_i = ~sys_clk_i;
	// ----------------------------------------
	// drivers and scoreboard
	// ----------------------------------------
	task automatic check(input string nm, input logic [34:0] seen);
		logic [34:0] exp;
		exp = expq.size() > 0 ? expq.pop_front() : 'x;
		if (exp[34] === 1'b1)
			seen[33:0] = exp[33:0];
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cp_write(input logic [3:0] r, input logic [2:0] o, input logic [31:0] v);
		cp_reg_i <= r;
		cp_op2_i <= o;
		cp_wdata_i <= v;
		cp_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		cp_wr_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic cp_read(input logic [3:0] r, input logic [2:0] o, input logic [31:0] e);
		expq.push_back({3'h0, e});
		cp_reg_i <= r;
		cp_op2_i <= o;
		cp_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		cp_rd_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic access(input logic ip, input logic [31:0] a, input logic [34:0] e);
		int n = 0;
		expq.push_back(e);
		if (ip) begin
			i_req_i <= 1'b1;
			i_addr_i <= a;
		end else begin
			d_req_i <= 1'b1;
			d_addr_i <= a;
			d_wr_i <= 1'($random(seed));
			d_size_i <= 2'({$random(seed)} % 3);
		end
		@(posedge sys_clk_i);
		i_req_i <= 1'b0;
		d_req_i <= 1'b0;
		while (!(i_done_o | i_abort_o | d_done_o | d_abort_o) && n < 300) begin
			@(negedge sys_clk_i);
			n++;
		end
		if (n >= 300)
			fails++;
		@(posedge sys_clk_i);
	endtask
	task automatic fetched(input int n);
		expq.push_back(35'(n));
		check("fetches", 35'(fetches));
	endtask
	task automatic test_done();
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(negedge sys_clk_i) begin
		if (cp_rvalid_o === 1'b1)
			check("cp_rdata", {3'h0, cp_rdata_o});
		if ((d_done_o | d_abort_o) === 1'b1)
			check("d_port", {d_abort_o, d_cache_o, d_buf_o, d_phys_o});
		if ((i_done_o | i_abort_o) === 1'b1)
			check("i_port", {i_abort_o, i_cache_o, i_buf_o, i_phys_o});
	end
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		cp_read(4'h1, 3'h0, 32'h0);
		cp_write(4'h2, 3'h0, 32'hFFFFFFFF);
		cp_read(4'h2, 3'h0, 32'hFFFFC000);
		cp_write(4'h3, 3'h0, 32'hA55A3CC3);
		cp_read(4'h3, 3'h0, 32'hA55A3CC3);
		cp_read(4'h8, 3'h0, 32'h0);
		cp_read(4'h4, 3'h0, 32'h0);
		repeat (4) begin
			off = 32'($random(seed));
			access(1'b0, off, {3'h0, off});
			access(1'b1, off, {3'h0, off});
		end
		cp_write(4'h1, 3'h0, 32'hFFFFFFFF);
		cp_read(4'h1, 3'h0, 32'h00000303);
		cp_write(4'h1, 3'h0, 32'h1);
		cp_write(4'h2, 3'h0, 32'h00004000);
		cp_write(4'h3, 3'h0, 32'h3);
		cp_write(4'hA, 3'h0, 32'h0C300001);
		cp_read(4'hA, 3'h0, 32'h0C300001);
		cp_read(4'hA, 3'h1, 32'h0);
		off = 32'($random(seed)) & 32'h000FFFFC;
		slow <= 1'b1;
		access(1'b0, 32'h12300000 | off, {3'h3, 32'hABC00000 | off});
		fetched(1);
		off = off ^ 32'h000FFFF0;
		access(1'b0, 32'h12300000 | off, {3'h3, 32'hABC00000 | off});
		fetched(1);
		cp_read(4'hA, 3'h0, 32'h0C400001);
		slow <= 1'b0;
		access(1'b1, 32'h12300000 | off, {3'h3, 32'hABC00000 | off});
		fetched(2);
		access(1'b0, 32'h20056788, {3'h0, 32'h77777788});
		fetched(4);
		access(1'b0, 32'h30000010, {1'b1, 34'h0});
		cp_read(4'h5, 3'h0, 32'h000000F5);
		cp_read(4'h6, 3'h0, 32'h30000010);
		access(1'b1, 32'h40000000, {1'b1, 34'h0});
		cp_read(4'h6, 3'h0, 32'h30000010);
		cp_write(4'h3, 3'h0, 32'h0);
		access(1'b0, 32'h12300000 | off, {1'b1, 34'h0});
		cp_read(4'h5, 3'h0, 32'h00000009);
		cp_write(4'h3, 3'h0, 32'h1);
		access(1'b0, 32'h12300000 | off, {3'h3, 32'hABC00000 | off});
		cp_write(4'h8, 3'h0, 32'h0);
		access(1'b0, 32'h20056788, {3'h0, 32'h77777788});
		access(1'b1, 32'h12300000 | off, {3'h3, 32'hABC00000 | off});
		fetched(7);
		cp_crm_i <= 4'h6;
		cp_write(4'h8, 3'h1, 32'h20056000);
		access(1'b0, 32'h20056788, {3'h0, 32'h77777788});
		fetched(9);
		cp_write(4'hD, 3'h0, 32'h02000000);
		access(1'b0, 32'h00100010, {3'h3, 32'h55500010});
		fetched(10);
		d_priv_i <= 1'b0;
		access(1'b0, 32'h00100010, {1'b1, 34'h0});
		cp_read(4'h5, 3'h0, 32'h0000000D);
		test_done();
	end
endmodule
`default_nettype wire
